// [rtl/arsb_pkg.sv]
package arsb_pkg;

    localparam int ARSB_NUM_REG = 4;
    localparam int ARSB_DATA_W = 32;
    localparam int ARSB_REG_W = 8;
    localparam int ARSB_CODE_MAX_W = 7;
    localparam int ARSB_MV_W = 16;
    localparam int ARSB_MIN_ADDR_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [7:0] ARSB_IDX_IO_BUCK = 8'hB8;
    localparam logic [7:0] ARSB_IDX_PERIPH_BUCK = 8'hB9;
    localparam logic [7:0] ARSB_IDX_LINEAR_ONE = 8'hBA;
    localparam logic [7:0] ARSB_IDX_LINEAR_TWO = 8'hBB;
    localparam logic [1:0] ARSB_WORD_LSB = 2'h0;

    // Slot order inside the bank
    localparam int ARSB_SLOT_IO = 0;
    localparam int ARSB_SLOT_PERIPH = 1;
    localparam int ARSB_SLOT_LIN1 = 2;
    localparam int ARSB_SLOT_LIN2 = 3;

    // Field layout
    localparam int ARSB_SLEEP_BIT = 7;
    localparam int ARSB_LDO_RSVD_BIT = 6;
    localparam int ARSB_BUCK_CODE_W = 7;
    localparam int ARSB_LDO_CODE_W = 6;

    // Set-point scale
    localparam logic [15:0] ARSB_BUCK_BASE_MV = 16'h0320;
    localparam logic [15:0] ARSB_LDO_BASE_MV = 16'h0258;
    localparam logic [15:0] ARSB_STEP_MV = 16'h0014;

    localparam logic [7:0] ARSB_REG_RST = 8'h00;

    localparam logic [7:0] ARSB_IDX_TABLE [ARSB_NUM_REG] = '{
        ARSB_IDX_IO_BUCK, ARSB_IDX_PERIPH_BUCK, ARSB_IDX_LINEAR_ONE, ARSB_IDX_LINEAR_TWO};
    localparam int ARSB_CODE_W_TABLE [ARSB_NUM_REG] = '{
        ARSB_BUCK_CODE_W, ARSB_BUCK_CODE_W, ARSB_LDO_CODE_W, ARSB_LDO_CODE_W};
    localparam logic [15:0] ARSB_BASE_TABLE [ARSB_NUM_REG] = '{
        ARSB_BUCK_BASE_MV, ARSB_BUCK_BASE_MV, ARSB_LDO_BASE_MV, ARSB_LDO_BASE_MV};

    typedef struct packed {
        logic [ARSB_NUM_REG-1:0][ARSB_REG_W-1:0] regs;
        logic [ARSB_DATA_W-1:0] rdata;
        logic altApplied;
    } arsb_state_t;

    typedef struct packed {
        logic sleepSel;
        logic [ARSB_CODE_MAX_W-1:0] code;
        logic [ARSB_MV_W-1:0] millivolt;
    } arsb_dec_state_t;

endpackage : arsb_pkg

// [rtl/arsb_setpoint_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module arsb_setpoint_decode
    import arsb_pkg::*;
#(
    parameter int CODE_W = ARSB_BUCK_CODE_W,
    parameter logic [15:0] BASE_MV = ARSB_BUCK_BASE_MV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic altSettingSel,
    input wire logic sleepIn,
    input wire logic [ARSB_CODE_MAX_W-1:0] codeIn,
    output logic sleepOut,
    output logic [ARSB_CODE_MAX_W-1:0] codeOut,
    output logic [ARSB_MV_W-1:0] millivolt
);

    if (CODE_W < 1 || CODE_W > ARSB_CODE_MAX_W) begin : gBadCodeW
        $error("arsb_setpoint_decode: CODE_W out of range");
    end

    arsb_dec_state_t st_r;
    arsb_dec_state_t st_nxt;
    logic [ARSB_CODE_MAX_W-1:0] codeMasked;
    logic [ARSB_MV_W-1:0] codeWide;

    // Bits above the field (reserved on linear regulators) never reach the output
    assign codeMasked = codeIn & ARSB_CODE_MAX_W'((1 << CODE_W) - 1);
    assign codeWide = {{(ARSB_MV_W-ARSB_CODE_MAX_W){1'b0}}, codeMasked};

    // Alternate fields drive the regulator only while the alternate set is selected
    always_comb begin
        st_nxt = '0;
        if (altSettingSel) begin
            st_nxt.sleepSel = sleepIn;
            st_nxt.code = codeMasked;
            st_nxt.millivolt = ARSB_MV_W'(BASE_MV + ARSB_STEP_MV * codeWide);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sleepOut = st_r.sleepSel;
    assign codeOut = st_r.code;
    assign millivolt = st_r.millivolt;

endmodule : arsb_setpoint_decode

`default_nettype wire

// [rtl/arsb_setpoint_bank.sv]
// Behaviour
// - IO buck bit 7: 0 synchronous, 1 sleep
// - IO buck code: 0.80 V plus 20 mV steps
// - Peripheral buck bit 7: 1 sleep, 0 synchronous
// - Peripheral buck code: 0.80 V, 20 mV steps
// - Linear bit 7: 0 normal, 1 sleep; bit 6 reserved
// - Linear code bits 5:0: 0.60 V, 20 mV steps
`timescale 1ns/1ps
`default_nettype none

module arsb_setpoint_bank
    import arsb_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ARSB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [ARSB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic altSettingSel,
    output logic altApplied,
    output logic ioBuckAltSleepSel,
    output logic [ARSB_BUCK_CODE_W-1:0] ioBuckAltVoltageCode,
    output logic [ARSB_MV_W-1:0] ioBuckAltMillivolt,
    output logic periphBuckAltSleepSel,
    output logic [ARSB_BUCK_CODE_W-1:0] periphBuckAltVoltageCode,
    output logic [ARSB_MV_W-1:0] periphBuckAltMillivolt,
    output logic linearOneAltSleepSel,
    output logic [ARSB_LDO_CODE_W-1:0] linearOneAltVoltageCode,
    output logic [ARSB_MV_W-1:0] linearOneAltMillivolt,
    output logic linearTwoAltSleepSel,
    output logic [ARSB_LDO_CODE_W-1:0] linearTwoAltVoltageCode,
    output logic [ARSB_MV_W-1:0] linearTwoAltMillivolt
);

    if (ADDR_W < ARSB_MIN_ADDR_W) begin : gBadAddrW
        $error("arsb_setpoint_bank: ADDR_W too small for the register map");
    end

    arsb_state_t st_r;
    arsb_state_t st_nxt;

    logic [ARSB_NUM_REG-1:0] addrMatch;
    logic hit;
    logic [1:0] hitIdx;
    logic setupRead;
    logic accessWrite;

    logic [ARSB_NUM_REG-1:0] sleepVec;
    logic [ARSB_NUM_REG-1:0][ARSB_CODE_MAX_W-1:0] codeVec;
    logic [ARSB_NUM_REG-1:0][ARSB_MV_W-1:0] mvVec;

    // Address decode and per-register regulator view
    for (genvar i = 0; i < ARSB_NUM_REG; i++) begin : gReg
        localparam logic [ADDR_W-1:0] REG_ADDR = ADDR_W'({ARSB_IDX_TABLE[i], ARSB_WORD_LSB});

        assign addrMatch[i] = (paddr == REG_ADDR);

        arsb_setpoint_decode #(
            .CODE_W(ARSB_CODE_W_TABLE[i]),
            .BASE_MV(ARSB_BASE_TABLE[i])
        ) uDecode (
            .clk(clk),
            .rst_n(rst_n),
            .altSettingSel(altSettingSel),
            .sleepIn(st_r.regs[i][ARSB_SLEEP_BIT]),
            .codeIn(st_r.regs[i][ARSB_CODE_MAX_W-1:0]),
            .sleepOut(sleepVec[i]),
            .codeOut(codeVec[i]),
            .millivolt(mvVec[i])
        );
    end

    assign hit = |addrMatch;

    always_comb begin
        hitIdx = 2'h0;
        for (int k = 0; k < ARSB_NUM_REG; k++) begin
            if (addrMatch[k]) begin
                hitIdx = 2'(k);
            end
        end
    end

    assign setupRead = psel && !penable && !pwrite;
    assign accessWrite = psel && penable && pwrite;

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        st_nxt = st_r;
        st_nxt.altApplied = altSettingSel;
        // Read data prepared in setup so it is registered for the access phase
        if (setupRead) begin
            st_nxt.rdata = hit ? {{(ARSB_DATA_W-ARSB_REG_W){1'b0}}, st_r.regs[hitIdx]} : '0;
        end
        // Every bit, reserved bit 6 included, is stored and read back
        if (accessWrite && hit && pstrb[0]) begin
            st_nxt.regs[hitIdx] = pwdata[ARSB_REG_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r.regs <= {ARSB_NUM_REG{ARSB_REG_RST}};
            st_r.rdata <= '0;
            st_r.altApplied <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign altApplied = st_r.altApplied;

    // Regulator-facing outputs, zero while the primary set is in force
    assign ioBuckAltSleepSel = sleepVec[ARSB_SLOT_IO];
    assign ioBuckAltVoltageCode = codeVec[ARSB_SLOT_IO][ARSB_BUCK_CODE_W-1:0];
    assign ioBuckAltMillivolt = mvVec[ARSB_SLOT_IO];
    assign periphBuckAltSleepSel = sleepVec[ARSB_SLOT_PERIPH];
    assign periphBuckAltVoltageCode = codeVec[ARSB_SLOT_PERIPH][ARSB_BUCK_CODE_W-1:0];
    assign periphBuckAltMillivolt = mvVec[ARSB_SLOT_PERIPH];
    assign linearOneAltSleepSel = sleepVec[ARSB_SLOT_LIN1];
    assign linearOneAltVoltageCode = codeVec[ARSB_SLOT_LIN1][ARSB_LDO_CODE_W-1:0];
    assign linearOneAltMillivolt = mvVec[ARSB_SLOT_LIN1];
    assign linearTwoAltSleepSel = sleepVec[ARSB_SLOT_LIN2];
    assign linearTwoAltVoltageCode = codeVec[ARSB_SLOT_LIN2][ARSB_LDO_CODE_W-1:0];
    assign linearTwoAltMillivolt = mvVec[ARSB_SLOT_LIN2];

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [ARSB_MV_W-1:0] ioExpMv;
    logic [ARSB_MV_W-1:0] periphExpMv;
    logic [ARSB_MV_W-1:0] lin1ExpMv;
    logic [ARSB_MV_W-1:0] lin2ExpMv;

    assign ioExpMv = ARSB_MV_W'(ARSB_BUCK_BASE_MV + ARSB_STEP_MV * ARSB_MV_W'(st_r.regs[ARSB_SLOT_IO][6:0]));
    assign periphExpMv = ARSB_MV_W'(ARSB_BUCK_BASE_MV
        + ARSB_STEP_MV * ARSB_MV_W'(st_r.regs[ARSB_SLOT_PERIPH][6:0]));
    assign lin1ExpMv = ARSB_MV_W'(ARSB_LDO_BASE_MV + ARSB_STEP_MV * ARSB_MV_W'(st_r.regs[ARSB_SLOT_LIN1][5:0]));
    assign lin2ExpMv = ARSB_MV_W'(ARSB_LDO_BASE_MV + ARSB_STEP_MV * ARSB_MV_W'(st_r.regs[ARSB_SLOT_LIN2][5:0]));

    ioSleep_a: assert property (altSettingSel |=> ioBuckAltSleepSel == $past(st_r.regs[ARSB_SLOT_IO][7]))
        else $error("IO buck sleep select does not follow bit 7");

    ioMillivolt_a: assert property (altSettingSel |=> ioBuckAltMillivolt == $past(ioExpMv))
        else $error("IO buck set-point in mV is wrong");

    periphSleep_a: assert property (
        altSettingSel && st_r.regs[ARSB_SLOT_PERIPH][7] |=> periphBuckAltSleepSel)
        else $error("Peripheral buck not in sleep with bit 7 set");

    periphMillivolt_a: assert property (altSettingSel ##1 altSettingSel
        |-> periphBuckAltMillivolt == $past(periphExpMv) && periphBuckAltVoltageCode == $past(st_r.regs[1][6:0]))
        else $error("Peripheral buck set-point is wrong");

    linearSleep_a: assert property (altSettingSel |=>
        linearOneAltSleepSel == $past(st_r.regs[ARSB_SLOT_LIN1][7])
        && linearTwoAltSleepSel == $past(st_r.regs[ARSB_SLOT_LIN2][7]))
        else $error("Linear regulator sleep select wrong");

    linearMillivolt_a: assert property (altSettingSel |=>
        linearOneAltMillivolt == $past(lin1ExpMv) && linearTwoAltMillivolt == $past(lin2ExpMv))
        else $error("Linear regulator set-point wrong or reserved bit leaked");

    primaryGate_a: assert property (!altSettingSel |=>
        !altApplied && ioBuckAltMillivolt == '0 && !periphBuckAltSleepSel && linearTwoAltVoltageCode == '0)
        else $error("Alternate setting applied while primary set selected");

    writeRead_a: assert property (
        accessWrite && addrMatch[ARSB_SLOT_LIN1] && pstrb[0]
        ##1 psel && !penable && !pwrite && addrMatch[ARSB_SLOT_LIN1]
        |=> prdata == {{(ARSB_DATA_W-ARSB_REG_W){1'b0}}, $past(pwdata[7:0], 2)})
        else $error("Read back differs from written value");

    unmapped_a: assert property (psel && penable && !hit |-> pslverr ##1 $stable(st_r.regs))
        else $error("Unmapped access not refused");

    strobeOff_a: assert property (
        accessWrite && !pstrb[0]
        |=> $stable(st_r.regs))
        else $error("Write with byte strobe off changed a register");

    writeLands_a: assert property (
        accessWrite && hit && pstrb[0]
        |=> st_r.regs[$past(hitIdx)] == $past(pwdata[ARSB_REG_W-1:0]))
        else $error("Write did not land in the addressed register");

    unmappedRead_a: assert property (
        setupRead && !hit
        |=> prdata == '0)
        else $error("Unmapped read returned nonzero data");

    mappedOk_a: assert property (
        psel && penable && hit
        |-> !pslverr)
        else $error("Mapped access flagged as error");

    errOnlyAccess_a: assert property (
        !(psel && penable)
        |-> !pslverr)
        else $error("Error flagged outside the access phase");

    readyHigh_a: assert property (
        psel && penable
        |-> pready)
        else $error("Access phase stalled");

    rdataHold_a: assert property (
        !setupRead
        |=> $stable(prdata))
        else $error("Read data changed without a read setup");

    readTop_a: assert property (
        psel && penable && !pwrite
        |-> prdata[ARSB_DATA_W-1:ARSB_REG_W] == '0)
        else $error("Upper read data bits not zero");

    readNoWrite_a: assert property (
        psel && !pwrite
        |=> $stable(st_r.regs))
        else $error("Read changed a register");

    setupNoWrite_a: assert property (
        psel && !penable
        |=> $stable(st_r.regs))
        else $error("Setup phase changed a register");

    idleNoWrite_a: assert property (
        !psel
        |=> $stable(st_r.regs))
        else $error("Idle bus changed a register");

    writeOther_a: assert property (
        accessWrite && addrMatch[ARSB_SLOT_IO]
        |=> $stable(st_r.regs[ARSB_SLOT_LIN2]))
        else $error("Write to one register disturbed another");

    hitOneHot_a: assert property ($onehot0(addrMatch))
        else $error("Address matches more than one register");

    ioCode_a: assert property (
        altSettingSel
        |=> ioBuckAltVoltageCode == $past(st_r.regs[ARSB_SLOT_IO][ARSB_BUCK_CODE_W-1:0]))
        else $error("IO buck code does not follow the register");

    periphSync_a: assert property (
        altSettingSel && !st_r.regs[ARSB_SLOT_PERIPH][ARSB_SLEEP_BIT]
        |=> !periphBuckAltSleepSel)
        else $error("Peripheral buck not synchronous with bit 7 clear");

    lin1Code_a: assert property (
        altSettingSel
        |=> linearOneAltVoltageCode == $past(st_r.regs[ARSB_SLOT_LIN1][ARSB_LDO_CODE_W-1:0]))
        else $error("First linear regulator code wrong");

    lin2Code_a: assert property (
        altSettingSel
        |=> linearTwoAltVoltageCode == $past(st_r.regs[ARSB_SLOT_LIN2][ARSB_LDO_CODE_W-1:0]))
        else $error("Second linear regulator code wrong");

    // Highest linear set-point; anything above means the reserved bit leaked
    logic [ARSB_MV_W-1:0] ldoMaxMv;
    assign ldoMaxMv = ARSB_MV_W'(ARSB_LDO_BASE_MV + ARSB_STEP_MV * ARSB_MV_W'((1 << ARSB_LDO_CODE_W) - 1));

    linRange_a: assert property (
        linearOneAltMillivolt <= ldoMaxMv
        && linearTwoAltMillivolt <= ldoMaxMv)
        else $error("Linear regulator set-point out of range");

    altApplied_a: assert property (
        1'b1
        |=> altApplied == $past(altSettingSel))
        else $error("Applied flag does not follow the set selection");

    primaryIo_a: assert property (
        !altSettingSel
        |=> !ioBuckAltSleepSel && ioBuckAltVoltageCode == '0)
        else $error("IO buck alternate fields leak under primary set");

    primaryPeriph_a: assert property (
        !altSettingSel
        |=> periphBuckAltVoltageCode == '0 && periphBuckAltMillivolt == '0)
        else $error("Peripheral buck alternate fields leak under primary set");

    primaryLinear_a: assert property (
        !altSettingSel
        |=> !linearOneAltSleepSel && linearOneAltVoltageCode == '0 && linearOneAltMillivolt == '0
        && !linearTwoAltSleepSel && linearTwoAltMillivolt == '0)
        else $error("Linear alternate fields leak under primary set");

    ioWrite_c: cover property (accessWrite && addrMatch[ARSB_SLOT_IO] ##1 altSettingSel [*2]);
    linSleep_c: cover property (altSettingSel && st_r.regs[ARSB_SLOT_LIN2][7] ##1 linearTwoAltSleepSel);
    unmapped_c: cover property (pslverr);
    altToggle_c: cover property (altSettingSel ##1 !altSettingSel ##1 altSettingSel);
    strobeOff_c: cover property (accessWrite && !pstrb[0]);

endmodule : arsb_setpoint_bank

`default_nettype wire

// [verification/arsb_setpoint_bank_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define ARSB_CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); end end

module arsb_setpoint_bank_tb_top;
    import arsb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic altSettingSel = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, altApplied;
    logic ioS, peS, l1S, l2S;
    logic [6:0] ioC, peC;
    logic [5:0] l1C, l2C;
    logic [15:0] ioM, peM, l1M, l2M;
    int failures = 0;
    int samples_checked = 0;
    logic [7:0] model [4];
    logic [31:0] rd;
    logic err;
    bit busHeld = 1'b0;

    arsb_setpoint_bank #(.ADDR_W(12)) arsb_setpoint_bank_inst (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .altSettingSel(altSettingSel), .altApplied(altApplied),
        .ioBuckAltSleepSel(ioS), .ioBuckAltVoltageCode(ioC), .ioBuckAltMillivolt(ioM),
        .periphBuckAltSleepSel(peS), .periphBuckAltVoltageCode(peC), .periphBuckAltMillivolt(peM),
        .linearOneAltSleepSel(l1S), .linearOneAltVoltageCode(l1C), .linearOneAltMillivolt(l1M),
        .linearTwoAltSleepSel(l2S), .linearTwoAltVoltageCode(l2C), .linearTwoAltMillivolt(l2M)
    );

    always #5 clk = ~clk;

    function automatic logic [11:0] adr(input int i);
        return 12'({ARSB_IDX_TABLE[i], ARSB_WORD_LSB});
    endfunction : adr

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
        input bit hold = 1'b0);
        if (!busHeld) begin
            @(posedge clk);
        end
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // Held bus: the next setup follows at once
        busHeld = hold;
        if (!hold) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic check_outs();
        logic s;
        s = altSettingSel;
        `ARSB_CHK(altApplied, s)
        `ARSB_CHK(ioS, s & model[0][7])
        `ARSB_CHK(ioC, s ? model[0][6:0] : 7'h00)
        `ARSB_CHK(ioM, s ? 16'(800 + 20 * int'(model[0][6:0])) : 16'h0000)
        `ARSB_CHK(peS, s & model[1][7])
        `ARSB_CHK(peC, s ? model[1][6:0] : 7'h00)
        `ARSB_CHK(peM, s ? 16'(800 + 20 * int'(model[1][6:0])) : 16'h0000)
        `ARSB_CHK(l1S, s & model[2][7])
        `ARSB_CHK(l1C, s ? model[2][5:0] : 6'h00)
        `ARSB_CHK(l1M, s ? 16'(600 + 20 * int'(model[2][5:0])) : 16'h0000)
        `ARSB_CHK(l2S, s & model[3][7])
        `ARSB_CHK(l2C, s ? model[3][5:0] : 6'h00)
        `ARSB_CHK(l2M, s ? 16'(600 + 20 * int'(model[3][5:0])) : 16'h0000)
    endtask : check_outs

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        finish_test();
    end

    initial begin
        logic [31:0] v;
        void'($urandom(89065));
        for (int i = 0; i < 4; i++) model[i] = 8'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, adr(i), 32'h0, 4'hF);
            `ARSB_CHK(rd, 32'h0)
        end
        @(posedge clk);
        #1 check_outs();
        @(posedge clk);
        altSettingSel <= 1'b1;
        @(posedge clk);
        #1 check_outs();
        for (int r = 0; r < 6; r++) begin
            @(posedge clk);
            altSettingSel <= (r != 3);
            for (int i = 0; i < 4; i++) begin
                v = (r < 2) ? {32{r[0]}} : $urandom;
                apb(1'b1, adr(i), v, 4'hF, 1'b1);
                `ARSB_CHK(err, 1'b0)
                model[i] = v[7:0];
                apb(1'b0, adr(i), 32'h0, 4'hF);
                `ARSB_CHK(rd, {24'h0, model[i]})
                @(posedge clk);
                #1 check_outs();
            end
        end
        apb(1'b1, adr(0), ~{24'h0, model[0]}, 4'hE);
        apb(1'b0, adr(0), 32'h0, 4'hF);
        `ARSB_CHK(rd, {24'h0, model[0]})
        apb(1'b1, 12'h2F0, 32'h5A, 4'hF);
        `ARSB_CHK(err, 1'b1)
        apb(1'b0, 12'h2F0, 32'h0, 4'hF);
        `ARSB_CHK({err, rd}, 33'h100000000)
        apb(1'b1, adr(1) + 12'h001, ~{24'h0, model[1]}, 4'hF);
        `ARSB_CHK(err, 1'b1)
        apb(1'b0, adr(1), 32'h0, 4'hF);
        `ARSB_CHK(rd, {24'h0, model[1]})
        @(posedge clk);
        #1 check_outs();
        finish_test();
    end
endmodule : arsb_setpoint_bank_tb_top
`default_nettype wire
